// ### common/sfpp_pkg.sv
// Package for the serial flash page-program and clear-status handler.
// Assumes a 100 MHz system clock that oversamples the programmer's transfer clock.
package sfpp_pkg;
    localparam logic [7:0] SFPP_CMD_CLEAR   = 8'h50;
    localparam logic [7:0] SFPP_CMD_PROGRAM = 8'h41;
    localparam int         SFPP_PAGE_BYTES  = 256;
    localparam int         SFPP_BYTE_BITS   = 8;
    localparam int         SFPP_BLOCK_LSB   = 8;
    localparam int         SFPP_FLAG_ERASE  = 0;
    localparam int         SFPP_FLAG_PROG   = 1;
    localparam int         SFPP_FLAG_LOCK   = 2;
    localparam int         SFPP_FLASH_NS    = 100;
    localparam int         SFPP_CLK_NS      = 10;
    localparam int         SFPP_FLASH_CYC   = (SFPP_FLASH_NS + SFPP_CLK_NS - 1) / SFPP_CLK_NS;
    localparam logic [2:0] SFPP_FLAGS_RESET = 3'h0;

    typedef enum logic [2:0] {
        SFPP_IDLE  = 3'b000,
        SFPP_ADDR  = 3'b001,
        SFPP_DATA  = 3'b011,
        SFPP_WRITE = 3'b010,
        SFPP_CLEAR = 3'b110,
        SFPP_SKIP  = 3'b111
    } sfpp_state_t;

    typedef struct packed {
        logic        req;
        logic [15:0] page;
        logic [7:0]  offset;
        logic [7:0]  data;
    } sfpp_wr_t;
endpackage

// ### core/sfpp_core.sv
// Device-side handler for clear-status and page-program serial commands.
// Assumes the programmer obeys the busy line and never reprograms a page.
`timescale 1ns/1ps
module sfpp_core (
    // System
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    // Serial link from programmer
    input  wire logic            serial_transfer_clock,
    input  wire logic            serial_receive_line,
    output logic                 busy_indicator_output,
    // Protection and flash write port
    input  wire logic [15:0]     block_lock,
    input  wire logic            flash_ready,
    output sfpp_pkg::sfpp_wr_t   flash_wr,
    // Status
    output logic [2:0]           error_flag_bits,
    output logic                 program_done
);
    import sfpp_pkg::*;

    logic [2:0]  sclk_sync_reg;
    logic [1:0]  rxd_sync_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bit_cnt_reg;
    logic        byte_vld;
    logic [7:0]  byte_val;
    logic        sclk_rise;
    sfpp_state_t state_reg;
    logic [1:0]  addr_cnt_reg;
    logic [15:0] page_reg;
    logic [8:0]  rx_cnt_reg;
    logic        locked_reg;
    logic [7:0]  buf_data [2];
    logic [7:0]  buf_off [2];
    logic [1:0]  buf_cnt_reg;
    logic        buf_wp_reg;
    logic        buf_rp_reg;
    logic        buf_in_vld;
    logic        buf_in_rdy;
    logic        buf_out_vld;
    logic        buf_out_rdy;
    logic [8:0]  wr_cnt_reg;
    logic [3:0]  clr_cnt_reg;

    // Link synchronisers, first stage read only by second
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_sync_reg <= 3'h7; // Idle level high, no false rise after reset
            rxd_sync_reg  <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], serial_transfer_clock};
            rxd_sync_reg  <= {rxd_sync_reg[0], serial_receive_line};
        end
    end
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];

    // Byte assembly, LSB first on rising transfer clock
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 3'h0;
        end else if (sclk_rise) begin
            shift_reg   <= {rxd_sync_reg[1], shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end
    assign byte_vld = sclk_rise && (bit_cnt_reg == 3'h7);
    assign byte_val = {rxd_sync_reg[1], shift_reg[7:1]};

    // Two-entry buffer between receiver and flash write
    assign buf_in_vld  = byte_vld && (state_reg == SFPP_DATA) && !locked_reg;
    assign buf_in_rdy  = (buf_cnt_reg != 2'h2);
    assign buf_out_vld = (buf_cnt_reg != 2'h0);
    assign buf_out_rdy = flash_ready;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            buf_cnt_reg <= 2'h0;
            buf_wp_reg  <= 1'b0;
            buf_rp_reg  <= 1'b0;
        end else begin
            if (buf_in_vld && buf_in_rdy) begin
                buf_data[buf_wp_reg] <= byte_val;
                buf_off[buf_wp_reg]  <= rx_cnt_reg[7:0];
                buf_wp_reg           <= ~buf_wp_reg;
            end
            if (buf_out_vld && buf_out_rdy)
                buf_rp_reg <= ~buf_rp_reg;
            buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_in_vld && buf_in_rdy}
                           - {1'b0, buf_out_vld && buf_out_rdy};
        end
    end

    // Flash write port, one request per accepted byte
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flash_wr   <= '0;
            wr_cnt_reg <= 9'h000;
        end else begin
            flash_wr.req <= buf_out_vld && buf_out_rdy;
            if (buf_out_vld && buf_out_rdy) begin
                flash_wr.page   <= page_reg;
                flash_wr.offset <= buf_off[buf_rp_reg];
                flash_wr.data   <= buf_data[buf_rp_reg];
                wr_cnt_reg      <= wr_cnt_reg + 9'h001;
            end else if (state_reg == SFPP_IDLE) begin
                wr_cnt_reg <= 9'h000;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg    <= SFPP_IDLE;
            addr_cnt_reg <= 2'h0;
            page_reg     <= 16'h0000;
            rx_cnt_reg   <= 9'h000;
            locked_reg   <= 1'b0;
            clr_cnt_reg  <= 4'h0;
        end else begin
            case (state_reg)
                SFPP_IDLE: begin
                    if (byte_vld) begin
                        if (byte_val == SFPP_CMD_PROGRAM) begin
                            state_reg    <= SFPP_ADDR;
                            addr_cnt_reg <= 2'h0;
                        end else if (byte_val == SFPP_CMD_CLEAR) begin
                            state_reg   <= SFPP_CLEAR;
                            clr_cnt_reg <= 4'h0;
                        end
                    end
                end
                SFPP_ADDR: begin
                    if (byte_vld) begin
                        if (addr_cnt_reg == 2'h0) begin
                            page_reg[7:0] <= byte_val;
                            addr_cnt_reg  <= 2'h1;
                        end else begin
                            page_reg[15:8] <= byte_val;
                            locked_reg     <= block_lock[byte_val[7:4]];
                            rx_cnt_reg     <= 9'h000;
                            state_reg      <= SFPP_DATA;
                        end
                    end
                end
                SFPP_DATA: begin
                    if (byte_vld) begin
                        rx_cnt_reg <= rx_cnt_reg + 9'h001;
                        if (rx_cnt_reg == 9'(SFPP_PAGE_BYTES - 1))
                            state_reg <= SFPP_WRITE;
                    end
                end
                SFPP_WRITE: begin
                    if (locked_reg || (wr_cnt_reg == 9'(SFPP_PAGE_BYTES) && !buf_out_vld))
                        state_reg <= SFPP_SKIP;
                end
                SFPP_CLEAR: begin
                    clr_cnt_reg <= clr_cnt_reg + 4'h1;
                    if (clr_cnt_reg == 4'(SFPP_FLASH_CYC - 1))
                        state_reg <= SFPP_IDLE;
                end
                SFPP_SKIP: state_reg <= SFPP_IDLE;
                default:   state_reg <= SFPP_IDLE;
            endcase
        end
    end

    // Status flags and completion pulse
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            error_flag_bits <= SFPP_FLAGS_RESET;
            program_done    <= 1'b0;
        end else begin
            program_done <= (state_reg == SFPP_SKIP);
            if (state_reg == SFPP_CLEAR && clr_cnt_reg == 4'h0)
                error_flag_bits <= SFPP_FLAGS_RESET;
            else if (state_reg == SFPP_WRITE && locked_reg) begin
                error_flag_bits[SFPP_FLAG_PROG] <= 1'b1;
                error_flag_bits[SFPP_FLAG_LOCK] <= 1'b1;
            end
        end
    end

    // Busy high from command byte until ready again
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            busy_indicator_output <= 1'b0;
        else
            busy_indicator_output <= (state_reg != SFPP_IDLE) && (state_reg != SFPP_SKIP);
    end
endmodule

// ### verification/sfpp_core_assertions.sv
// Port checks for the page-program handler.
// Bound to sfpp_core; sees its ports only.
`timescale 1ns/1ps
module sfpp_core_assertions (
    // Watched ports
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire logic               busy_indicator_output,
    input wire logic               flash_ready,
    input wire sfpp_pkg::sfpp_wr_t flash_wr,
    input wire logic [2:0]         error_flag_bits,
    input wire logic               program_done
);
    import sfpp_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence flags_cleared;
        $past(error_flag_bits) != 3'h0 && error_flag_bits == 3'h0;
    endsequence
    sequence busy_ends;
        busy_indicator_output ##[1:14] !busy_indicator_output;
    endsequence
    clear_ends_a: assert property (flags_cleared |-> busy_ends) else $error("clear end");
    write_ready_a: assert property (flash_wr.req |-> $past(flash_ready)) else $error("no ready");
    write_busy_a: assert property (flash_wr.req |-> busy_indicator_output) else $error("idle write");
    done_pulse_a: assert property (program_done |=> !program_done) else $error("long done");
    done_idle_a: assert property (program_done |-> $fell(busy_indicator_output)) else $error("done busy");
    erase_zero_a: assert property (!error_flag_bits[0]) else $error("erase flag");
    lock_flags_a: assert property ($rose(error_flag_bits[2]) |-> error_flag_bits[1]) else $error("lock");
    page_stable_a: assert property (flash_wr.req && $past(flash_wr.req) |-> $stable(flash_wr.page)) else $error("page");
endmodule

bind sfpp_core sfpp_core_assertions i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .flash_wr(flash_wr),
    .busy_indicator_output(busy_indicator_output), .flash_ready(flash_ready),
    .error_flag_bits(error_flag_bits), .program_done(program_done));

// ### verification/sfpp_prog.sv
// Serial programmer model driving the link.
// Assumes busy comes from the device.
`timescale 1ns/1ps
module sfpp_prog (
    // Link
    output logic      sclk,
    output logic      sdat,
    input  wire logic busy
);
    initial begin
        sclk = 1'h1;
        sdat = 1'h1;
    end
    task automatic put(logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            sclk = 1'h0;
            sdat = b[i];
            #80 sclk = 1'h1;
            #(i < 7 ? 80 : 40);
        end
        sdat = ~sdat;
    endtask
    task automatic cmd(logic [7:0] b);
        for (int k = 0; k < 9000 && busy !== 1'h0; k++) #10;
        put(b);
    endtask
endmodule

// ### verification/sfpp_core_tb_top.sv
// Bench for the page-program handler.
// Assumes the programmer model sfpp_prog.
`timescale 1ns/1ps
module sfpp_core_tb_top;
    import sfpp_pkg::*;
    logic        clk_sys = 1'h0;
    logic        rst_n = 1'h0;
    logic        flash_ready = 1'h1;
    logic [15:0] exp_page = 16'h0;
    logic        sclk, sdat, busy, done;
    logic [2:0]  flags;
    sfpp_wr_t    wr;
    int          err_count = 0, tests_run = 0, n_wr = 0, n_done = 0;
    always #5 clk_sys = ~clk_sys;
    sfpp_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_transfer_clock(sclk), .serial_receive_line(sdat),
        .busy_indicator_output(busy), .block_lock(16'h0008), .flash_ready(flash_ready), .flash_wr(wr),
        .error_flag_bits(flags), .program_done(done));
    sfpp_prog i_prog (.sclk(sclk), .sdat(sdat), .busy(busy));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        flash_ready <= #1 ~flash_ready;
        if (done === 1'h1) n_done++;
        if (wr.req === 1'h1) begin
            check("page", wr.page, exp_page);
            check("data", 16'(wr.data), 16'(8'(n_wr) ^ 8'hA5));
            check("offset", 16'(wr.offset), 16'(n_wr));
            n_wr++;
        end
    end
    task automatic wait_busy(logic v);
        for (int k = 0; k < 3000 && busy !== v; k++) @(posedge clk_sys);
        #1 check("busy", 16'(busy), 16'(v));
    endtask
    task automatic prog_page(logic [15:0] page, int writes, logic [2:0] fl);
        n_wr = 0;
        n_done = 0;
        exp_page = page;
        i_prog.cmd(SFPP_CMD_PROGRAM);
        i_prog.put(page[7:0]);
        i_prog.put(page[15:8]);
        for (int i = 0; i < SFPP_PAGE_BYTES; i++) i_prog.put(8'(i) ^ 8'hA5);
        wait_busy(1'h0);
        @(posedge clk_sys);
        #1 check("writes", 16'(n_wr), 16'(writes));
        check("done", 16'(n_done), 16'h1);
        check("flags", 16'(flags), 16'(fl));
        $display("program %h finished", page);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'h1;
        repeat (3) @(posedge clk_sys);
        prog_page(16'h3412, 0, 3'h6);
        i_prog.cmd(8'hFF);
        repeat (40) @(posedge clk_sys);
        #1 check("ignored", 16'(busy), 16'h0);
        i_prog.cmd(SFPP_CMD_CLEAR);
        wait_busy(1'h1);
        wait_busy(1'h0);
        check("cleared", 16'(flags), 16'h0);
        $display("clear finished");
        prog_page(16'h217E, SFPP_PAGE_BYTES, 3'h0);
        final_report;
    end
    initial begin
        #900000;
        err_count++;
        final_report;
    end
endmodule
